// ### hdl/cal_ctrl.v
// Calibration control register bank with Wishbone slave.
// Assumes one clock mclk; trigger and alarm pins are asynchronous.
`default_nettype none
`include "cal_ctrl_map.vh"

module cal_ctrl (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire [9:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg         wb_ack_o,
   input  wire        cal_trigger_pin,
   input  wire        alarm_pin,
   input  wire        fg_complete_flag_in,
   input  wire        bg_stopped_in,
   output reg         cal_status_pin,
   output wire        irq,
   output wire        cal_clear,
   output wire        fg_active,
   output wire        fg_os_active,
   output wire        bg_active,
   output wire        bg_os_active,
   output wire        offset_filter_enable
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg  [7:0] run_ctrl_ff;
   reg  [7:0] setup_ff;
   reg  [7:0] pin_setup_ff;
   reg  [7:0] sw_trig_ff;
   reg  [2:0] irq_stat_ff;
   reg  [2:0] irq_mask_ff;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire [7:0] idx;
   wire       req;
   wire       wr;
   wire       lane0;
   reg  [7:0] rd_mux;
   reg        hit;
   wire       rd_req;
   wire       wr_run_ctrl;
   wire       wr_setup;
   wire       wr_pin_setup;
   wire       wr_sw_trig;
   wire       wr_irq_stat;
   wire       wr_irq_mask;

   // ----------------------------------------
   // Synchronised pins and sequencer links
   // ----------------------------------------
   wire [1:0] pins_sync;
   wire       trig_sync;
   wire       alarm_sync;
   wire       trig_eff;
   wire       fg_complete_flag;
   wire       halted;
   reg        fg_prev_ff;
   reg        halt_prev_ff;
   reg        alarm_prev_ff;
   wire [2:0] irq_event;
   reg  [2:0] nxt_irq_stat;
   reg        nxt_cal_status;
   wire       fg_cal_run;
   wire       bg_cal_enable;
   wire       fg_offset_cal_enable;
   wire       bg_offset_cal_enable;
   wire       hw_trigger_select;
   wire       sw_trigger_bit;
   wire [1:0] stat_sel;
   wire [7:0] state_word;
   wire [2:0] irq_pending;

   // Word index from byte address
   assign idx   = wb_adr_i[9:2];
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr    = req & wb_we_i;
   assign lane0 = wb_sel_i[0];

   // ----------------------------------------
   // Access strobes
   // ----------------------------------------

   // One read strobe, one write strobe per writable register
   assign rd_req       = req & ~wb_we_i;
   assign wr_run_ctrl  = wr & lane0 & hit & (idx == `RUN_CTRL_IDX);
   assign wr_setup     = wr & lane0 & hit & (idx == `SETUP_IDX);
   assign wr_pin_setup = wr & lane0 & hit & (idx == `PIN_SETUP_IDX);
   assign wr_sw_trig   = wr & lane0 & hit & (idx == `SW_TRIG_IDX);
   assign wr_irq_stat  = wr & lane0 & hit & (idx == `IRQ_STAT_IDX);
   assign wr_irq_mask  = wr & lane0 & hit & (idx == `IRQ_MASK_IDX);

   // ----------------------------------------
   // Wishbone handshake
   // ----------------------------------------

   // Ack one cycle after request, then drop
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read data captured with ack
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_req) begin
         wb_dat_o <= {24'h00_0000, rd_mux};
      end
   end

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------

   // Unmapped indices read as zero
   always @* begin
      rd_mux = 8'h00;
      hit    = 1'b1;
      case (idx)
         `RUN_CTRL_IDX:  rd_mux = run_ctrl_ff;
         `SETUP_IDX:     rd_mux = setup_ff;
         `STATE_IDX:     rd_mux = state_word;
         `PIN_SETUP_IDX: rd_mux = pin_setup_ff;
         `SW_TRIG_IDX:   rd_mux = sw_trig_ff;
         `IRQ_STAT_IDX:  rd_mux = {5'h00, irq_stat_ff};
         `IRQ_MASK_IDX:  rd_mux = {5'h00, irq_mask_ff};
         default:        hit    = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------

   // Run enable: start or hold calibration
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         run_ctrl_ff <= `RUN_CTRL_RST;
      end else if (wr_run_ctrl) begin
         run_ctrl_ff <= wb_dat_i[7:0];
      end
   end

   // Calibration setup; software writes it only while held
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         setup_ff <= `SETUP_RST;
      end else if (wr_setup) begin
         setup_ff <= wb_dat_i[7:0];
      end
   end

   // Pin setup: trigger source and status select
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_setup_ff <= `PIN_SETUP_RST;
      end else if (wr_pin_setup) begin
         pin_setup_ff <= wb_dat_i[7:0];
      end
   end

   // Software trigger, resets high
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sw_trig_ff <= `SW_TRIG_RST;
      end else if (wr_sw_trig) begin
         sw_trig_ff <= wb_dat_i[7:0];
      end
   end

   // Interrupt mask
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_ff <= `IRQ_MASK_RST;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= wb_dat_i[2:0];
      end
   end

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------

   // Trigger and alarm pins through two flops
   pin_sync #(
      .W (2)
   ) u_sync (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .pin_in  ({alarm_pin, cal_trigger_pin}),
      .pin_out (pins_sync)
   );

   assign trig_sync  = pins_sync[0];
   assign alarm_sync = pins_sync[1];

   // ----------------------------------------
   // Register fields
   // ----------------------------------------

   // Setup bits steering the sequencer
   assign fg_cal_run           = setup_ff[`SETUP_FG];
   assign bg_cal_enable        = setup_ff[`SETUP_BG];
   assign fg_offset_cal_enable = setup_ff[`SETUP_OS];
   assign bg_offset_cal_enable = setup_ff[`SETUP_BGOS];

   // Pin setup and software trigger fields
   assign hw_trigger_select = pin_setup_ff[`PIN_TRIG_SEL];
   assign sw_trigger_bit    = sw_trig_ff[0];
   assign stat_sel          = pin_setup_ff[`PIN_STAT_HI:`PIN_STAT_LO];

   // Status word; reserved bits 7-2 read zero
   assign state_word = {6'h00, halted, fg_complete_flag};

   // ----------------------------------------
   // Trigger source select
   // ----------------------------------------

   // Pin when selected, else software bit
   assign trig_eff = hw_trigger_select ? trig_sync : sw_trigger_bit;

   // ----------------------------------------
   // Calibration sequencer
   // ----------------------------------------

   // Start, clear, foreground and background phases
   cal_sequencer u_seq (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .run_en         (run_ctrl_ff[0]),
      .fg_run         (fg_cal_run),
      .bg_en          (bg_cal_enable),
      .fg_os_en       (fg_offset_cal_enable),
      .bg_os_en       (bg_offset_cal_enable),
      .trig           (trig_eff),
      .fg_complete_flag_in     (fg_complete_flag_in),
      .bg_stopped_in  (bg_stopped_in),
      .cal_clear      (cal_clear),
      .fg_active      (fg_active),
      .fg_os_active   (fg_os_active),
      .bg_active      (bg_active),
      .bg_os_active   (bg_os_active),
      .fg_complete_ff (fg_complete_flag),
      .halted_ff      (halted)
   );

   // Offset filter follows its setup bit
   assign offset_filter_enable = setup_ff[`SETUP_OSFILT];

   // ----------------------------------------
   // Status pin
   // ----------------------------------------

   // Source select; reserved codes 1 and 3 hold low
   always @* begin
      case (stat_sel)
         `STAT_SEL_FG:    nxt_cal_status = fg_complete_flag;
         `STAT_SEL_ALARM: nxt_cal_status = alarm_sync;
         default:         nxt_cal_status = 1'b0;
      endcase
   end

   // Registered pin, glitch free on select change
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cal_status_pin <= 1'b0;
      end else begin
         cal_status_pin <= nxt_cal_status;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------

   // Previous levels for rising edge events
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fg_prev_ff    <= 1'b0;
         halt_prev_ff  <= 1'b0;
         alarm_prev_ff <= 1'b0;
      end else begin
         fg_prev_ff    <= fg_complete_flag;
         halt_prev_ff  <= halted;
         alarm_prev_ff <= alarm_sync;
      end
   end

   assign irq_event[`IRQ_FG]    = fg_complete_flag & ~fg_prev_ff;
   assign irq_event[`IRQ_HALT]  = halted & ~halt_prev_ff;
   assign irq_event[`IRQ_ALARM] = alarm_sync & ~alarm_prev_ff;

   // Write one to clear; a new event wins
   always @* begin
      nxt_irq_stat = irq_stat_ff;
      if (wr_irq_stat)
         nxt_irq_stat = irq_stat_ff & ~wb_dat_i[2:0];
      nxt_irq_stat = nxt_irq_stat | irq_event;
   end

   // Sticky status
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_ff <= 3'h0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // Level interrupt while unmasked bit set
   assign irq_pending = irq_stat_ff & irq_mask_ff;
   assign irq         = |irq_pending;

endmodule

`default_nettype wire

// ### hdl/cal_ctrl_map.vh
// Register map and field layout of the calibration control block.
// Assumes a 32-bit bus; each 8-bit register sits in byte lane 0.
`ifndef CAL_CTRL_MAP_VH
`define CAL_CTRL_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4*idx)
// ----------------------------------------
`define RUN_CTRL_IDX   8'h61
`define SETUP_IDX      8'h62
`define STATE_IDX      8'h6A
`define PIN_SETUP_IDX  8'h6B
`define SW_TRIG_IDX    8'h6C
`define IRQ_STAT_IDX   8'h70
`define IRQ_MASK_IDX   8'h71

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RUN_CTRL_RST   8'h01
`define SETUP_RST      8'h01
`define PIN_SETUP_RST  8'h00
`define SW_TRIG_RST    8'h01
`define IRQ_MASK_RST   3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SETUP_FG       0
`define SETUP_BG       1
`define SETUP_OS       2
`define SETUP_BGOS     3
`define SETUP_OSFILT   4
`define PIN_TRIG_SEL   0
`define PIN_STAT_LO    1
`define PIN_STAT_HI    2
`define IRQ_FG         0
`define IRQ_HALT       1
`define IRQ_ALARM      2

// ----------------------------------------
// Status pin source codes
// ----------------------------------------
`define STAT_SEL_FG    2'h0
`define STAT_SEL_ALARM 2'h2

`endif

// ### hdl/pin_sync.v
// Two-stage synchroniser for pins from outside mclk.
// Assumes inputs are slow levels; one bit per stage pair.
`default_nettype none

module pin_sync #(
   parameter W = 2
) (
   input  wire         mclk,
   input  wire         rst_b,
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] pin_out
);

   genvar i;

   // ----------------------------------------
   // One flop pair per bit
   // ----------------------------------------
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_ff;
         reg sync_ff;
         // First stage read only by second
         always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= pin_in[i];
               sync_ff <= meta_ff;
            end
         end
         assign pin_out[i] = sync_ff;
      end
   endgenerate

endmodule

`default_nettype wire

// ### hdl/cal_sequencer.v
// Calibration start/run sequencer.
// Assumes engine handshakes are on mclk; trig already synchronised.
`default_nettype none

module cal_sequencer (
   input  wire mclk,
   input  wire rst_b,
   input  wire run_en,
   input  wire fg_run,
   input  wire bg_en,
   input  wire fg_os_en,
   input  wire bg_os_en,
   input  wire trig,
   input  wire fg_complete_flag_in,
   input  wire bg_stopped_in,
   output wire cal_clear,
   output wire fg_active,
   output wire fg_os_active,
   output wire bg_active,
   output wire bg_os_active,
   output reg  fg_complete_ff,
   output reg  halted_ff
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam S_HOLD  = 3'b000;
   localparam S_CLEAR = 3'b001;
   localparam S_FG    = 3'b010;
   localparam S_BG    = 3'b011;
   localparam S_DONE  = 3'b100;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg       nxt_halted;

   // Next state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_HOLD:  if (run_en) nxt_state = S_CLEAR;
         S_CLEAR: begin
            if (!run_en) nxt_state = S_HOLD;
            else if (fg_run) nxt_state = S_FG;
            else if (bg_en) nxt_state = S_BG;
            else nxt_state = S_DONE;
         end
         S_FG: begin
            if (!run_en) nxt_state = S_HOLD;
            else if (fg_complete_flag_in) nxt_state = bg_en ? S_BG : S_DONE;
         end
         S_BG:    if (!run_en) nxt_state = S_HOLD;
         S_DONE:  if (!run_en) nxt_state = S_HOLD;
         default: nxt_state = S_HOLD;
      endcase
   end

   // Halted: bg parked at phase, or fg over with bg off
   always @* begin
      nxt_halted = 1'b0;
      if (state_ff == S_DONE)
         nxt_halted = 1'b1;
      else if (state_ff == S_BG)
         nxt_halted = ~trig & bg_stopped_in;
   end

   // State and flags
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff       <= S_HOLD;
         fg_complete_ff <= 1'b0;
         halted_ff      <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         halted_ff <= nxt_halted;
         if (state_ff == S_HOLD || state_ff == S_CLEAR)
            fg_complete_ff <= 1'b0;
         else if (state_ff == S_FG && fg_complete_flag_in)
            fg_complete_ff <= 1'b1;
      end
   end

   // Engine controls
   assign cal_clear    = (state_ff == S_CLEAR);
   assign fg_active    = (state_ff == S_FG);
   assign fg_os_active = fg_active & fg_run & fg_os_en;
   assign bg_active    = (state_ff == S_BG) & trig;
   assign bg_os_active = bg_active & bg_en & bg_os_en;

endmodule

`default_nettype wire

// ### hdl/cal_ctrl_dummy_unused.v
`default_nettype none
`default_nettype wire

// ### verification/cal_engine_model.sv
// Behavioural model of the calibration engine behind the block.
// Assumes the engine handshakes run on mclk; dly sets answer speed.
`default_nettype none

module cal_engine_model (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       fg_active,
   input  wire logic       bg_active,
   input  wire logic [7:0] dly,
   output var  logic       fg_complete_flag_in,
   output var  logic       bg_stopped_in
);
   logic [7:0] cnt_ff;

   // Foreground ends dly+1 cycles after start; parks when bg halts
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff        <= 8'h00;
         fg_complete_flag_in    <= 1'h0;
         bg_stopped_in <= 1'h0;
      end else begin
         cnt_ff        <= !fg_active ? 8'h00 : (cnt_ff <= dly ? cnt_ff + 8'h01 : cnt_ff);
         fg_complete_flag_in    <= fg_active && cnt_ff == dly;
         bg_stopped_in <= !bg_active;
      end
   end
endmodule
`default_nettype wire

// ### verification/cal_ctrl_asserts.sv
// Concurrent checks on the calibration control block's ports.
// Assumes the register map header is on the include path.
`default_nettype none
`include "cal_ctrl_map.vh"

module cal_ctrl_asserts (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_ack_o,
   input  wire logic        cal_status_pin,
   input  wire logic        cal_clear,
   input  wire logic        fg_active,
   input  wire logic        fg_os_active,
   input  wire logic        bg_active,
   input  wire logic        bg_os_active,
   input  wire logic        offset_filter_enable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   logic       wr_taken;
   logic [1:0] pin_sel_ff;
   logic [7:0] setup_sh_ff;

   // Write accepted this edge
   assign wr_taken = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

   // Shadow of the status pin select field
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         pin_sel_ff <= 2'h0;
      else if (wr_taken && wb_adr_i[9:2] == `PIN_SETUP_IDX)
         pin_sel_ff <= wb_dat_i[2:1];
   end

   // Shadow of the calibration setup register
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         setup_sh_ff <= `SETUP_RST;
      else if (wr_taken && wb_adr_i[9:2] == `SETUP_IDX)
         setup_sh_ff <= wb_dat_i[7:0];
   end

   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_filter_write: assert property (
      wr_taken && wb_adr_i[9:2] == `SETUP_IDX |=> offset_filter_enable == $past(wb_dat_i[4]))
      else $error("filter enable does not follow setup write");
   chk_fg_os_gate: assert property (
      fg_os_active == (fg_active && setup_sh_ff[`SETUP_FG] && setup_sh_ff[`SETUP_OS]))
      else $error("fg offset cal not gated by setup");
   chk_bg_os_gate: assert property (
      bg_os_active == (bg_active && setup_sh_ff[`SETUP_BG] && setup_sh_ff[`SETUP_BGOS]))
      else $error("bg offset cal not gated by setup");
   chk_pin_held_low: assert property (pin_sel_ff[0] && $past(pin_sel_ff[0]) |-> !cal_status_pin)
      else $error("status pin not low for select 1 or 3");
   chk_clear_first: assert property ($rose(fg_active) |-> $past(cal_clear))
      else $error("fg started without value clear");
   chk_run_stop: assert property (
      wr_taken && wb_adr_i[9:2] == `RUN_CTRL_IDX && !wb_dat_i[0] |-> ##2 !fg_active && !bg_active)
      else $error("calibration runs after run enable cleared");

   cover property ($rose(bg_os_active));
   cover property ($rose(fg_os_active));
   cover property (pin_sel_ff == 2'h2 && cal_status_pin);
endmodule

bind cal_ctrl cal_ctrl_asserts u_chk (.mclk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cal_status_pin, .cal_clear, .fg_active, .fg_os_active,
   .bg_active, .bg_os_active, .offset_filter_enable);
`default_nettype wire

// ### verification/cal_ctrl_tb.sv
// Self-checking bench for the calibration control block.
// Assumes the engine model and the register map header.
`default_nettype none
`include "cal_ctrl_map.vh"

module cal_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [9:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [3:0]  wb_sel_i;
   logic        cal_trigger_pin, alarm_pin, fg_complete_flag_in, bg_stopped_in, cal_status_pin, irq;
   logic        cal_clear, fg_active, fg_os_active, bg_active, bg_os_active, offset_filter_enable;
   logic [7:0]  dly, r;
   int          miscompares, n_checks;

   cal_ctrl dut (.mclk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
      .wb_stb_i, .wb_ack_o, .cal_trigger_pin, .alarm_pin, .fg_complete_flag_in, .bg_stopped_in, .cal_status_pin,
      .irq, .cal_clear, .fg_active, .fg_os_active, .bg_active, .bg_os_active, .offset_filter_enable);
   cal_engine_model eng (.mclk, .rst_b, .fg_active, .bg_active, .dly, .fg_complete_flag_in, .bg_stopped_in);

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic bad(input string m);
      miscompares++;
      $display("BAD t=%0t %s", $time, m);
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
         $display("BAD t=%0t got %h expected %h", $time, g, e);
      if (g !== e)
         miscompares++;
   endtask

   // One classic Wishbone cycle
   task automatic xfer(input logic w, input logic [3:0] s, input logic [7:0] i, input logic [7:0] d);
      int n;
      @(posedge mclk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_sel_i <= s;
      wb_adr_i <= {i, 2'h0};
      wb_dat_i <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      if (n >= 20) begin
         bad("no ack");
         tally_and_finish;
      end
      r = wb_dat_o[7:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i  <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'h1, 4'h1, i, d);
   endtask

   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      xfer(1'h0, 4'h1, i, 8'h00);
      chk(r, e);
   endtask

   // Poll the state register until it shows e
   task automatic pst(input logic [7:0] e);
      int n;
      n = 0;
      do begin
         xfer(1'h0, 4'h1, `STATE_IDX, 8'h00);
         n++;
      end while (r !== e && n < 50);
      chk(r, e);
      if (r !== e)
         tally_and_finish;
   endtask

   // Wait for fg_active (0), bg_active (1) or irq (2) to reach v
   task automatic wt(input logic [1:0] k, input logic v);
      int n;
      n = 0;
      while ((k == 0 ? fg_active : k == 1 ? bg_active : irq) !== v && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk({7'h00, n < 200}, 8'h01);
      if (n >= 200)
         tally_and_finish;
   endtask

   initial begin
      {mclk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, cal_trigger_pin, alarm_pin} = 7'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i, miscompares, n_checks} = 0;
      dly = 8'h02;
      repeat (3) @(posedge mclk);
      rst_b <= 1'h1;
      // Reset values, auto-start, interrupt
      rd(`PIN_SETUP_IDX, 8'h00);
      rd(`SW_TRIG_IDX, 8'h01);
      rd(`SETUP_IDX, 8'h01);
      rd(8'h50, 8'h00);
      pst(8'h03);
      rd(`IRQ_STAT_IDX, 8'h03);
      chk({7'h00, irq}, 8'h00);
      wr(`IRQ_MASK_IDX, 8'h01);
      wt(2, 1'h1);
      wr(`IRQ_STAT_IDX, 8'h01);
      chk({7'h00, irq}, 8'h00);
      rd(`IRQ_STAT_IDX, 8'h02);
      wr(`IRQ_MASK_IDX, 8'h00);
      $display("test registers done");
      // Status pin sources
      for (int k = 0; k < 4; k++) begin
         wr(`PIN_SETUP_IDX, 8'(k << 1));
         repeat (3) @(posedge mclk);
         chk({7'h00, cal_status_pin}, {7'h00, k == 0});
      end
      wr(`PIN_SETUP_IDX, 8'h04);
      alarm_pin <= 1'h1;
      repeat (5) @(posedge mclk);
      chk({7'h00, cal_status_pin}, 8'h01);
      alarm_pin <= 1'h0;
      repeat (5) @(posedge mclk);
      chk({7'h00, cal_status_pin}, 8'h00);
      rd(`IRQ_STAT_IDX, 8'h06);
      wr(`IRQ_STAT_IDX, 8'h07);
      $display("test status pin done");
      // Background run and pause
      wr(`RUN_CTRL_IDX, 8'h00);
      pst(8'h00);
      wr(`SETUP_IDX, 8'h1E);
      chk({7'h00, offset_filter_enable}, 8'h01);
      wr(`RUN_CTRL_IDX, 8'h01);
      wt(1, 1'h1);
      chk({6'h00, bg_os_active, fg_os_active}, 8'h02);
      pst(8'h00);
      wr(`SW_TRIG_IDX, 8'h00);
      wt(1, 1'h0);
      pst(8'h02);
      wr(`SW_TRIG_IDX, 8'h01);
      wt(1, 1'h1);
      pst(8'h00);
      $display("test background done");
      // Hardware trigger select
      wr(`PIN_SETUP_IDX, 8'h01);
      wt(1, 1'h0);
      cal_trigger_pin <= 1'h1;
      wt(1, 1'h1);
      wr(`SW_TRIG_IDX, 8'h00);
      repeat (4) @(posedge mclk);
      chk({7'h00, bg_active}, 8'h01);
      wr(`PIN_SETUP_IDX, 8'h00);
      wt(1, 1'h0);
      cal_trigger_pin <= 1'h0;
      wr(`SW_TRIG_IDX, 8'h01);
      $display("test trigger done");
      // Slow foreground with offset cal
      wr(`RUN_CTRL_IDX, 8'h00);
      wr(`SETUP_IDX, 8'h05);
      dly <= 8'h14;
      wr(`RUN_CTRL_IDX, 8'h01);
      wt(0, 1'h1);
      chk({7'h00, fg_os_active}, 8'h01);
      pst(8'h03);
      xfer(1'h1, 4'h0, `PIN_SETUP_IDX, 8'h06);
      rd(`PIN_SETUP_IDX, 8'h00);
      $display("test foreground done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
